/* design/temp_limit_fan_event_regs.v */
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`include "temp_limit_fan_event_regs.vh"

module temp_limit_fan_event_regs #(
  parameter ALARM_UNIT_CYCLES = `ALARM_UNIT_CYCLES,
  parameter STALL_TICKS = `STALL_TICKS
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [9:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire [7:0] temp_one,
  input wire [7:0] temp_two,
  input wire [7:0] temp_three,
  input wire [3:0] fan_count_over,
  input wire [3:0] fan_count_short,
  input wire [7:0] fan_alarm_interval,
  input wire [3:0] fan_duty_nonzero,
  input wire [3:0] fan_stopped,
  output reg [5:0] second_filter_len_a,
  output reg [5:0] second_filter_len_b,
  output reg [5:0] second_filter_len_c,
  output reg force_full_speed,
  output reg beeper_out,
  output reg power_event_output_n,
  output reg irq
);

  // Queue code to sample count
  function [5:0] queue_len;
    input [1:0] code;
    begin
      case (code)
        2'h1: queue_len = `QUEUE_LEN_CODE1;
        2'h2: queue_len = `QUEUE_LEN_CODE2;
        2'h3: queue_len = `QUEUE_LEN_CODE3;
        default: queue_len = 6'h00;
      endcase
    end
  endfunction

  // Index is mapped to a register
  function idx_hit;
    input [7:0] idx;
    begin
      case (idx)
        `IDX_TEMP_ONE, `IDX_TEMP_TWO, `IDX_TEMP_THREE,
        `IDX_S1_OVERHEAT, `IDX_S1_HIGH, `IDX_S2_OVERHEAT,
        `IDX_S2_HIGH, `IDX_S3_OVERHEAT, `IDX_S3_HIGH,
        `IDX_FILTER_QUEUE, `IDX_FAN_WAKE_EN, `IDX_FAN_STICKY,
        `IDX_FAN_LIVE_FAULT, `IDX_FAN_BEEP_FULL,
        `IDX_IRQ_STATUS, `IDX_IRQ_MASK: idx_hit = 1'b1;
        default: idx_hit = 1'b0;
      endcase
    end
  endfunction

  reg [7:0] s1_overheat_reg;
  reg [7:0] s1_high_reg;
  reg [7:0] s2_overheat_reg;
  reg [7:0] s2_high_reg;
  reg [7:0] s3_overheat_reg;
  reg [7:0] s3_high_reg;
  reg [7:0] filter_queue_reg;
  reg [3:0] wake_en_reg;
  reg [3:0] sticky_reg;
  reg [3:0] sticky_next;
  reg [3:0] live_fault_reg;
  reg [7:0] beep_full_reg;
  reg [2:0] irq_status_reg;
  reg [2:0] irq_status_next;
  reg [2:0] irq_mask_reg;
  reg [2:0] irq_event;
  reg live_prev_reg;
  reg force_prev_reg;
  reg [31:0] tick_cnt_reg;
  reg tick_reg;
  reg [8:0] short_cnt_reg [0:3];
  reg [11:0] stall_cnt_reg [0:3];
  reg [7:0] rd_data;
  reg force_now;
  reg [7:0] s1_overheat_next;
  reg [7:0] s1_high_next;
  reg [7:0] s2_overheat_next;
  reg [7:0] s2_high_next;
  reg [7:0] s3_overheat_next;
  reg [7:0] s3_high_next;
  reg [7:0] filter_queue_next;
  reg [3:0] wake_en_next;
  reg [7:0] beep_full_next;
  reg [2:0] irq_mask_next;
  integer i;

  wire [7:0] idx = paddr[9:2];
  wire setup = psel & ~penable;
  wire access = psel & penable & pready;
  wire wr = access & pwrite & ~pslverr;
  wire rd = access & ~pwrite & ~pslverr;

  // Read multiplexer, unused upper bits read zero
  always @* begin
    rd_data = 8'h00;
    case (idx)
      `IDX_TEMP_ONE: rd_data = temp_one;
      `IDX_TEMP_TWO: rd_data = temp_two;
      `IDX_TEMP_THREE: rd_data = temp_three;
      `IDX_S1_OVERHEAT: rd_data = s1_overheat_reg;
      `IDX_S1_HIGH: rd_data = s1_high_reg;
      `IDX_S2_OVERHEAT: rd_data = s2_overheat_reg;
      `IDX_S2_HIGH: rd_data = s2_high_reg;
      `IDX_S3_OVERHEAT: rd_data = s3_overheat_reg;
      `IDX_S3_HIGH: rd_data = s3_high_reg;
      `IDX_FILTER_QUEUE: rd_data = filter_queue_reg;
      `IDX_FAN_WAKE_EN: rd_data = {4'h0, wake_en_reg};
      `IDX_FAN_STICKY: rd_data = {4'h0, sticky_reg};
      `IDX_FAN_LIVE_FAULT: rd_data = {4'h0, live_fault_reg};
      `IDX_FAN_BEEP_FULL: rd_data = beep_full_reg;
      `IDX_IRQ_STATUS: rd_data = {5'h00, irq_status_reg};
      `IDX_IRQ_MASK: rd_data = {5'h00, irq_mask_reg};
      default: rd_data = 8'h00;
    endcase
  end

  // No wait state; ready is registered from setup so bus outputs come from flops
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      // Unmapped indices are refused in the same cycle as ready
      pslverr <= setup & ~idx_hit(idx);
    end
  end

  // Read data captured at setup and held until the next setup
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup && idx_hit(idx) && !pwrite) begin
      prdata <= {24'h000000, rd_data};
    end else if (setup) begin
      // Writes and refused reads return zero
      prdata <= 32'h00000000;
    end
  end

  // Next values of software registers; refused or read accesses change nothing
  always @* begin
    s1_overheat_next = s1_overheat_reg;
    s1_high_next = s1_high_reg;
    s2_overheat_next = s2_overheat_reg;
    s2_high_next = s2_high_reg;
    s3_overheat_next = s3_overheat_reg;
    s3_high_next = s3_high_reg;
    filter_queue_next = filter_queue_reg;
    wake_en_next = wake_en_reg;
    beep_full_next = beep_full_reg;
    irq_mask_next = irq_mask_reg;
    if (wr) begin
      case (idx)
        `IDX_S1_OVERHEAT: s1_overheat_next = pwdata[7:0];
        `IDX_S1_HIGH: s1_high_next = pwdata[7:0];
        `IDX_S2_OVERHEAT: s2_overheat_next = pwdata[7:0];
        `IDX_S2_HIGH: s2_high_next = pwdata[7:0];
        `IDX_S3_OVERHEAT: s3_overheat_next = pwdata[7:0];
        `IDX_S3_HIGH: s3_high_next = pwdata[7:0];
        // Low two bits are not storage and read zero
        `IDX_FILTER_QUEUE: filter_queue_next = {pwdata[7:2], 2'h0};
        // Upper wake bits are reserved and not stored
        `IDX_FAN_WAKE_EN: wake_en_next = pwdata[3:0];
        `IDX_FAN_BEEP_FULL: beep_full_next = pwdata[7:0];
        `IDX_IRQ_MASK: irq_mask_next = pwdata[2:0];
        // Read-only and flag indices store nothing here; sticky flag clears are made in the sticky block
        default: irq_mask_next = irq_mask_reg;
      endcase
    end
  end

  // Software registers, written at the access edge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_overheat_reg <= `RST_S1_OVERHEAT;
      s1_high_reg <= `RST_S1_HIGH;
      s2_overheat_reg <= `RST_S2_OVERHEAT;
      s2_high_reg <= `RST_S2_HIGH;
      s3_overheat_reg <= `RST_S3_OVERHEAT;
      s3_high_reg <= `RST_S3_HIGH;
      filter_queue_reg <= `RST_FILTER_QUEUE;
      wake_en_reg <= `RST_FAN_WAKE_EN;
      beep_full_reg <= `RST_FAN_BEEP_FULL;
      irq_mask_reg <= `RST_IRQ_MASK;
    end else begin
      s1_overheat_reg <= s1_overheat_next;
      s1_high_reg <= s1_high_next;
      s2_overheat_reg <= s2_overheat_next;
      s2_high_reg <= s2_high_next;
      s3_overheat_reg <= s3_overheat_next;
      s3_high_reg <= s3_high_next;
      filter_queue_reg <= filter_queue_next;
      wake_en_reg <= wake_en_next;
      beep_full_reg <= beep_full_next;
      irq_mask_reg <= irq_mask_next;
    end
  end

  // Sticky fan flags; a new event beats a same-cycle clear
  always @* begin
    sticky_next = sticky_reg;
    if (wr && idx == `IDX_FAN_STICKY) begin
      sticky_next = sticky_reg & ~pwdata[3:0];
    end
    sticky_next = sticky_next | fan_count_over;
  end

  // Alarm time base shared by all fans
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_reg <= 32'h00000000;
      tick_reg <= 1'b0;
    // Greater-or-equal so the count recovers if it ever overshoots
    end else if (tick_cnt_reg >= ALARM_UNIT_CYCLES - 1) begin
      tick_cnt_reg <= 32'h00000000;
      tick_reg <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h00000001;
      tick_reg <= 1'b0;
    end
  end

  // Per-fan fault timers; saturate so a long fault stays flagged
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < 4; i = i + 1) begin
        short_cnt_reg[i] <= 9'h000;
        stall_cnt_reg[i] <= 12'h000;
      end
      live_fault_reg <= 4'h0;
    end else begin
      for (i = 0; i < 4; i = i + 1) begin
        if (!fan_count_short[i]) begin
          short_cnt_reg[i] <= 9'h000;
        end else if (tick_reg && short_cnt_reg[i] != 9'h1ff) begin
          short_cnt_reg[i] <= short_cnt_reg[i] + 9'h001;
        end
        if (!(fan_duty_nonzero[i] && fan_stopped[i])) begin
          stall_cnt_reg[i] <= 12'h000;
        end else if (tick_reg && stall_cnt_reg[i] != 12'hfff) begin
          stall_cnt_reg[i] <= stall_cnt_reg[i] + 12'h001;
        end
        live_fault_reg[i] <= (short_cnt_reg[i] > {1'b0, fan_alarm_interval}) ||
                             (stall_cnt_reg[i] > STALL_TICKS);
      end
    end
  end

  // Full-speed request from enabled sensors
  always @* begin
    // enabled sensor above high limit
    // Strictly greater: a reading equal to the limit does not force
    force_now = (beep_full_reg[`FULL_S1_BIT] && temp_one > s1_high_reg) ||
                (beep_full_reg[`FULL_S2_BIT] && temp_two > s2_high_reg) ||
                (beep_full_reg[`FULL_S3_BIT] && temp_three > s3_high_reg);
  end

  // Interrupt events and read-to-clear status
  always @* begin
    irq_event = 3'h0;
    irq_event[`IRQ_FAN_COUNT_BIT] = |fan_count_over;
    // Edges, not levels, so a standing fault raises one event
    irq_event[`IRQ_LIVE_FAULT_BIT] = (|live_fault_reg) & ~live_prev_reg;
    irq_event[`IRQ_FORCE_MAX_BIT] = force_now & ~force_prev_reg;
    irq_status_next = irq_status_reg;
    // Only bits already returned to software are cleared
    if (rd && idx == `IDX_IRQ_STATUS) begin
      irq_status_next = irq_status_reg & ~prdata[2:0];
    end
    irq_status_next = irq_status_next | irq_event;
  end

  // Event state flops; flags and edge histories share one reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sticky_reg <= 4'h0;
      irq_status_reg <= 3'h0;
      live_prev_reg <= 1'b0;
      force_prev_reg <= 1'b0;
    end else begin
      sticky_reg <= sticky_next;
      irq_status_reg <= irq_status_next;
      // Histories reset low like their sources, so no edge follows reset
      live_prev_reg <= |live_fault_reg;
      force_prev_reg <= force_now;
    end
  end

  // Registered event outputs, one cycle behind the flags
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      force_full_speed <= 1'b0;
      beeper_out <= 1'b0;
      // Active low: idle high through reset
      power_event_output_n <= 1'b1;
      irq <= 1'b0;
    end else begin
      force_full_speed <= force_now;
      beeper_out <= |(sticky_reg & beep_full_reg[3:0]);
      power_event_output_n <= ~|(sticky_reg & wake_en_reg);
      // Level interrupt from unmasked status bits
      irq <= |(irq_status_reg & irq_mask_reg);
    end
  end

  // Decoded queue lengths; registered so a write never glitches them
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      second_filter_len_a <= 6'h00;
      second_filter_len_b <= 6'h00;
      second_filter_len_c <= 6'h00;
    end else begin
      second_filter_len_a <= queue_len(filter_queue_reg[`FQ_A_LSB +: 2]);
      second_filter_len_b <= queue_len(filter_queue_reg[`FQ_B_LSB +: 2]);
      second_filter_len_c <= queue_len(filter_queue_reg[`FQ_C_LSB +: 2]);
    end
  end

endmodule

/* design/temp_limit_fan_event_regs.vh */
`ifndef TEMP_LIMIT_FAN_EVENT_REGS_VH
`define TEMP_LIMIT_FAN_EVENT_REGS_VH

// Register indices; byte address is four times the index
`define IDX_TEMP_ONE 8'h72
`define IDX_TEMP_TWO 8'h74
`define IDX_TEMP_THREE 8'h76
`define IDX_S1_OVERHEAT 8'h82
`define IDX_S1_HIGH 8'h83
`define IDX_S2_OVERHEAT 8'h84
`define IDX_S2_HIGH 8'h85
`define IDX_S3_OVERHEAT 8'h86
`define IDX_S3_HIGH 8'h87
`define IDX_FILTER_QUEUE 8'h8e
`define IDX_FAN_WAKE_EN 8'h90
`define IDX_FAN_STICKY 8'h91
`define IDX_FAN_LIVE_FAULT 8'h92
`define IDX_FAN_BEEP_FULL 8'h93
`define IDX_IRQ_STATUS 8'ha0
`define IDX_IRQ_MASK 8'ha1

// Reset values
`define RST_S1_OVERHEAT 8'h64
`define RST_S1_HIGH 8'h55
`define RST_S2_OVERHEAT 8'h64
`define RST_S2_HIGH 8'h55
`define RST_S3_OVERHEAT 8'h55
`define RST_S3_HIGH 8'h46
`define RST_FILTER_QUEUE 8'h00
`define RST_FAN_WAKE_EN 4'h0
`define RST_FAN_BEEP_FULL 8'h00
`define RST_IRQ_MASK 3'h0

// Field positions
`define FQ_C_LSB 6
`define FQ_B_LSB 4
`define FQ_A_LSB 2
`define FULL_S1_BIT 5
`define FULL_S2_BIT 6
`define FULL_S3_BIT 7
`define IRQ_FAN_COUNT_BIT 0
`define IRQ_LIVE_FAULT_BIT 1
`define IRQ_FORCE_MAX_BIT 2

// Queue lengths selected by the filter queue codes
`define QUEUE_LEN_CODE1 6'h10
`define QUEUE_LEN_CODE2 6'h20
`define QUEUE_LEN_CODE3 6'h30

// Timing
`define CLK_PERIOD_NS 25
`define ALARM_UNIT_US 1000
`define STALL_TIME_MS 3000
`define ALARM_UNIT_CYCLES (`ALARM_UNIT_US * 1000 / `CLK_PERIOD_NS)
`define STALL_TICKS (`STALL_TIME_MS * 1000 / `ALARM_UNIT_US)

`endif

/* dv/regs_checker_sva.sv */
`timescale 1ns/1ps
`include "temp_limit_fan_event_regs.vh"
module regs_checker (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [9:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [7:0] temp_one,
  input wire [7:0] temp_two,
  input wire [7:0] temp_three,
  input wire [3:0] fan_count_short,
  input wire [3:0] fan_stopped,
  input wire force_full_speed,
  input wire [5:0] second_filter_len_b
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Setup cycle seen by the slave
  wire setup = psel && !penable;
  a_ready_after_setup: assert property (setup |=> pready)
    else $error("no ready after setup");
  a_ready_in_access: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_unmapped_err: assert property (setup && paddr[9:2] == 8'h70 |=> pslverr)
    else $error("unmapped index not refused");
  a_temp_read: assert property (setup && !pwrite && paddr[9:2] == `IDX_TEMP_ONE
    |=> prdata == {24'h0, $past(temp_one)}) else $error("temperature read wrong");
  a_upper_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  // Strictly greater compare: zero temps can never exceed a limit
  a_no_force_cold: assert property ((temp_one == 8'h0 && temp_two == 8'h0
    && temp_three == 8'h0) [*3] |-> !force_full_speed) else $error("force while cold");
  a_fault_quiet: assert property ((fan_count_short == 4'h0 && fan_stopped == 4'h0) [*4]
    ##0 setup && !pwrite && paddr[9:2] == `IDX_FAN_LIVE_FAULT |=> prdata == 32'h0)
    else $error("fault without cause");
  a_filter_code: assert property (second_filter_len_b == 6'd0 || second_filter_len_b == 6'd16
    || second_filter_len_b == 6'd32 || second_filter_len_b == 6'd48) else $error("bad length");
endmodule
bind temp_limit_fan_event_regs regs_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .pready, .pslverr, .temp_one, .temp_two, .temp_three, .fan_count_short,
  .fan_stopped, .force_full_speed, .second_filter_len_b);

/* dv/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
  logic [9:0] paddr = 10'h0;
  logic [31:0] pwdata = 32'h0, rd;
  logic [7:0] tt [3] = '{8'h0, 8'h0, 8'h0};
  logic [7:0] h, ai = 8'h02;
  logic [3:0] cov = 4'h0, csh = 4'h0, dnz = 4'h0, stp = 4'h0;
  logic [7:0] ix [11] = '{8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h87, 8'h8e, 8'h90, 8'h91,
    8'h93, 8'ha1};
  logic [7:0] rv [11] = '{8'h64, 8'h55, 8'h64, 8'h55, 8'h55, 8'h46, 8'h0, 8'h0, 8'h0, 8'h0,
    8'h0};
  wire [31:0] prdata;
  wire pready, pslverr, ffs, bp, pe_n, irq;
  wire [5:0] la, lb, lc;
  int n_fail = 0, num_checks = 0, cyc = 0;
  temp_limit_fan_event_regs #(.ALARM_UNIT_CYCLES(4), .STALL_TICKS(3)) u_dut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .temp_one(tt[0]),
    .temp_two(tt[1]), .temp_three(tt[2]), .fan_count_over(cov), .fan_count_short(csh),
    .fan_alarm_interval(ai), .fan_duty_nonzero(dnz), .fan_stopped(stp),
    .second_filter_len_a(la), .second_filter_len_b(lb), .second_filter_len_c(lc),
    .force_full_speed(ffs), .beeper_out(bp), .power_event_output_n(pe_n), .irq(irq));
  always #12.5 pclk = ~pclk;
  // Hang guard, far above the expected run length
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_fail++;
      final_report;
    end
  end
  task final_report;
    $display("checks %0d failures %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] x);
    num_checks++;
    if (s !== x) begin
      n_fail++;
      $display("ERROR %0t seen %h expected %h", $time, s, x);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge pclk);
  endtask
  // Setup, then access held until pready is sampled high
  task apb(input logic w, input logic [7:0] i, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {i, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [17:0] ql(input logic [1:0] c);
    ql = {3{6'(c) * 6'h10}};
  endfunction
  initial begin
    void'($urandom(2472));
    wt(6);
    presetn <= 1'b1;
    foreach (ix[i]) begin
      apb(0, ix[i], 32'h0);
      chk(rd, {24'h0, rv[i]});
    end
    for (int i = 0; i < 6; i++) begin
      h = 8'($urandom);
      apb(1, ix[i], {24'($urandom), h});
      apb(0, ix[i], 32'h0);
      chk(rd, {24'h0, h});
    end
    tt[0] <= 8'($urandom);
    apb(1, 8'h72, 32'hff);
    apb(0, 8'h72, 32'h0);
    chk(rd, {24'h0, tt[0]});
    apb(0, 8'h70, 32'h0);
    chk({rd[30:0], e}, 32'h1);
    for (int c = 0; c < 4; c++) begin
      apb(1, 8'h8e, {24'h0, c[1:0], c[1:0], c[1:0], 2'b11});
      apb(0, 8'h8e, 32'h0);
      chk(rd, {24'h0, c[1:0], c[1:0], c[1:0], 2'b00});
      chk({lc, lb, la}, ql(c[1:0]));
    end
    for (int f = 0; f < 4; f++) begin
      apb(1, 8'h90, 32'h1 << f);
      apb(1, 8'h93, 32'h1 << f);
      cov[f] <= 1'b1;
      wt(1);
      cov <= 4'h0;
      wt(3);
      chk({pe_n, bp}, 2'b01);
      apb(0, 8'h91, 32'h0);
      chk(rd, 32'h1 << f);
      apb(1, 8'h91, 32'hf0);
      apb(0, 8'h91, 32'h0);
      chk(rd, 32'h1 << f);
      apb(1, 8'h91, 32'h1 << f);
      apb(0, 8'h91, 32'h0);
      chk(rd, 32'h0);
      wt(3);
      chk({pe_n, bp}, 2'b10);
    end
    // Enables off: sticky set but outputs stay quiet; irq path raised and cleared
    apb(1, 8'h90, 32'h0);
    apb(1, 8'h93, 32'h0);
    apb(0, 8'ha0, 32'h0);
    apb(1, 8'ha1, 32'h1);
    cov <= 4'hf;
    wt(1);
    cov <= 4'h0;
    wt(3);
    chk({pe_n, bp, irq}, 3'b101);
    apb(0, 8'ha0, 32'h0);
    chk(rd[0], 1'b1);
    wt(3);
    chk(irq, 1'b0);
    apb(1, 8'h91, 32'hf);
    ai <= 8'(2 + $urandom % 4);
    wt(1);
    csh <= 4'h2;
    wt(4 * ai - 2);
    apb(0, 8'h92, 32'h0);
    chk(rd, 32'h0);
    wt(40);
    apb(0, 8'h92, 32'h0);
    chk(rd, 32'h2);
    csh <= 4'h0;
    dnz <= 4'h8;
    stp <= 4'hc;
    wt(40);
    apb(0, 8'h92, 32'h0);
    chk(rd, 32'h8);
    apb(0, 8'ha0, 32'h0);
    chk(rd, 32'h2);
    dnz <= 4'h0;
    stp <= 4'h0;
    wt(5);
    apb(0, 8'h92, 32'h0);
    chk(rd, 32'h0);
    for (int s = 0; s < 3; s++) begin
      h = 8'($urandom % 250);
      apb(1, ix[2 * s + 1], {24'h0, h});
      apb(1, 8'h93, 32'h20 << s);
      tt[s] <= h + 8'h1;
      wt(3);
      chk(ffs, 1'b1);
      tt[s] <= h;
      wt(3);
      chk(ffs, 1'b0);
      tt[s] <= 8'hff;
      apb(1, 8'h93, 32'h0);
      wt(3);
      chk(ffs, 1'b0);
      tt[s] <= 8'h0;
    end
    apb(0, 8'ha0, 32'h0);
    chk(rd, 32'h4);
    final_report;
  end
endmodule
